// *** hw/pic_top.sv ***
/*
 Four-level prioritized interrupt controller top: enables, priorities,
 arbitration, vectoring, nesting stack and power-down wakeup.
 Assumes the core pulses vector_taken when it jumps to irq_vector_ff and
 reti_done when a service routine returns; peripheral flags are levels.
*/
`timescale 1ns/100ps
module pic_top import pic_pkg::*; #(
   parameter int SRC_COUNT = NUM_SRC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Enable and priority registers
   input wire logic [7:0] enable_reg_a,
   input wire logic [7:0] enable_reg_b,
   input wire logic [7:0] prio_low_reg_a,
   input wire logic [7:0] prio_high_reg_a,
   input wire logic [7:0] prio_low_reg_b,
   input wire logic [7:0] prio_high_reg_b,
   // External pins and trigger types
   input wire logic ext0_req_pin_n,
   input wire logic ext1_req_pin_n,
   input wire logic ext0_trigger_type,
   input wire logic ext1_trigger_type,
   // Peripheral flags
   input wire logic timer0_ovf_flag,
   input wire logic timer1_ovf_flag,
   input wire logic serial_tx_flag,
   input wire logic serial_rx_flag,
   input wire logic brownout_flag,
   input wire logic twowire_attention_flag,
   input wire logic keypad_flag,
   input wire logic cmp1_flag,
   input wire logic cmp2_flag,
   input wire logic watchdog_ovf_flag,
   input wire logic conv_done_flag,
   // Core handshake
   input wire logic vector_taken,
   input wire logic reti_done,
   input wire logic cpu_power_down,
   input wire logic cpu_idle,
   // Outputs to core
   output logic irq_req_ff,
   output logic [7:0] irq_vector_ff,
   output logic [3:0] irq_source_ff,
   output logic [1:0] active_level_ff,
   output logic in_service_ff,
   output logic wakeup_ff,
   output logic ext0_req_flag,
   output logic ext1_req_flag
);
   // ----------------------------------------------------------------
   // Machine-cycle tick
   // ----------------------------------------------------------------
   logic [2:0] mcyc_ff;
   logic [2:0] nxt_mcyc;
   wire mcyc_tick = (mcyc_ff == MCYC_LAST);
   assign nxt_mcyc = mcyc_tick ? 3'h0 : mcyc_ff + 3'h1;

   // Prescaler for the pin samplers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mcyc_ff <= 3'h0;
      end else begin
         mcyc_ff <= nxt_mcyc;
      end
   end

   // ----------------------------------------------------------------
   // External request samplers
   // ----------------------------------------------------------------
   logic ext0_flag;
   logic ext1_flag;
   logic ack_ext0;
   logic ack_ext1;

   pic_ext_sampler u_ext0 (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ext_req_pin_n(ext0_req_pin_n),
      .sample_tick(mcyc_tick),
      .trigger_type(ext0_trigger_type),
      .vector_ack(ack_ext0),
      .req_flag(ext0_flag)
   );
   pic_ext_sampler u_ext1 (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ext_req_pin_n(ext1_req_pin_n),
      .sample_tick(mcyc_tick),
      .trigger_type(ext1_trigger_type),
      .vector_ack(ack_ext1),
      .req_flag(ext1_flag)
   );

   // ----------------------------------------------------------------
   // Source gathering: flags, enables, levels
   // ----------------------------------------------------------------
   logic [SRC_COUNT-1:0] src_flag;
   logic [SRC_COUNT-1:0] src_en;
   logic [SRC_COUNT-1:0] src_phi;
   logic [SRC_COUNT-1:0] src_plo;
   wire global_irq_enable = enable_reg_a[A_GLOBAL];

   // Map flags and register bits to source order
   assign src_flag = {cmp1_flag, conv_done_flag, watchdog_ovf_flag, cmp2_flag, keypad_flag,
                      twowire_attention_flag, brownout_flag, serial_tx_flag | serial_rx_flag,
                      timer1_ovf_flag, ext1_flag, timer0_ovf_flag, ext0_flag} ;
   assign src_en = {enable_reg_b[B_CMP1], enable_reg_b[B_CONV], enable_reg_a[A_WDT],
                    enable_reg_b[B_CMP2], enable_reg_b[B_KEY], enable_reg_b[B_TWI],
                    enable_reg_a[A_BOD], enable_reg_a[A_SER], enable_reg_a[A_TMR1],
                    enable_reg_a[A_EXT1], enable_reg_a[A_TMR0], enable_reg_a[A_EXT0]};
   assign src_phi = {prio_high_reg_b[B_CMP1], prio_high_reg_b[B_CONV], prio_high_reg_a[A_WDT],
                     prio_high_reg_b[B_CMP2], prio_high_reg_b[B_KEY], prio_high_reg_b[B_TWI],
                     prio_high_reg_a[A_BOD], prio_high_reg_a[A_SER], prio_high_reg_a[A_TMR1],
                     prio_high_reg_a[A_EXT1], prio_high_reg_a[A_TMR0], prio_high_reg_a[A_EXT0]};
   assign src_plo = {prio_low_reg_b[B_CMP1], prio_low_reg_b[B_CONV], prio_low_reg_a[A_WDT],
                     prio_low_reg_b[B_CMP2], prio_low_reg_b[B_KEY], prio_low_reg_b[B_TWI],
                     prio_low_reg_a[A_BOD], prio_low_reg_a[A_SER], prio_low_reg_a[A_TMR1],
                     prio_low_reg_a[A_EXT1], prio_low_reg_a[A_TMR0], prio_low_reg_a[A_EXT0]};

   // Pending mask and level, both in source order
   logic [SRC_COUNT-1:0] pend;
   logic [1:0] lvl [SRC_COUNT];

   // Pending mask per source
   genvar gi;
   generate
      for (gi = 0; gi < SRC_COUNT; gi++) begin : g_src
         assign pend[gi] = src_flag[gi] & src_en[gi] & global_irq_enable;
         assign lvl[gi] = {src_phi[gi], src_plo[gi]};
      end
   endgenerate

   // ----------------------------------------------------------------
   // Arbitration: highest level, then best rank
   // ----------------------------------------------------------------
   function automatic logic better(input logic [1:0] la, input logic [3:0] ra,
                                   input logic [1:0] lb, input logic [3:0] rb);
      better = (la > lb) || ((la == lb) && (ra < rb));
   endfunction

   logic win_valid;
   logic [3:0] win_src;
   logic [1:0] win_lvl;

   // Pick the winning pending source
   always_comb begin
      win_valid = 1'b0;
      win_src = 4'h0;
      win_lvl = 2'h0;
      for (int i = 0; i < SRC_COUNT; i++) begin
         if (pend[i] && (!win_valid || better(lvl[i], RANK_TAB[i], win_lvl, RANK_TAB[win_src]))) begin
            win_valid = 1'b1;
            win_src = 4'(i);
            win_lvl = lvl[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // Nesting: one in-service bit per level
   // ----------------------------------------------------------------
   logic [NUM_LVL-1:0] isr_lvl_ff;
   logic [NUM_LVL-1:0] nxt_isr_lvl;
   logic [NUM_LVL-1:0] top_bit;
   logic [NUM_LVL-1:0] push_bit;
   logic [1:0] req_lvl_ff;
   logic any_active;
   logic [1:0] cur_lvl;
   logic [1:0] nxt_lvl_out;
   pic_state_t nxt_state;
   wire take = vector_taken && irq_req_ff;

   // Highest active level
   always_comb begin
      cur_lvl = 2'h0;
      for (int l = 0; l < NUM_LVL; l++) begin
         if (isr_lvl_ff[l]) cur_lvl = 2'(l);
      end
   end
   assign any_active = |isr_lvl_ff;
   assign top_bit = any_active ? (4'h1 << cur_lvl) : 4'h0;
   assign push_bit = take ? (4'h1 << req_lvl_ff) : 4'h0;

   // Preempt only above the running level; top level cannot be exceeded
   wire grant_ok = win_valid && (!any_active || (win_lvl > cur_lvl));

   // Pop the top on return, push the taken level; both may fall in one cycle
   assign nxt_isr_lvl = (isr_lvl_ff & ~(reti_done ? top_bit : 4'h0)) | push_bit;
   assign nxt_state = (nxt_isr_lvl != 4'h0) ? ST_SERVE : ST_IDLE;

   // Level shown to the core follows the new stack top
   always_comb begin
      nxt_lvl_out = 2'h0;
      for (int l = 0; l < NUM_LVL; l++) begin
         if (nxt_isr_lvl[l]) nxt_lvl_out = 2'(l);
      end
   end

   // In-service level stack
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         isr_lvl_ff <= 4'h0;
      end else begin
         isr_lvl_ff <= nxt_isr_lvl;
      end
   end

   // ----------------------------------------------------------------
   // Request presentation and vectoring
   // ----------------------------------------------------------------
   assign ack_ext0 = take && (irq_source_ff == 4'(SRC_EXT0));
   assign ack_ext1 = take && (irq_source_ff == 4'(SRC_EXT1));

   // Request line; a taken request drops and stays low until a higher level wins or the routine returns
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq_req_ff <= 1'b0;
      end else begin
         irq_req_ff <= grant_ok && !take;
      end
   end

   // Vector, source and level of the current winner
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq_vector_ff <= 8'h00;
         irq_source_ff <= 4'h0;
         req_lvl_ff <= 2'h0;
      end else begin
         irq_vector_ff <= VEC_TAB[win_src];
         irq_source_ff <= win_src;
         req_lvl_ff <= win_lvl;
      end
   end

   // Highest in-service level
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         active_level_ff <= 2'h0;
      end else begin
         active_level_ff <= nxt_lvl_out;
      end
   end

   // Any routine in service
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         in_service_ff <= 1'b0;
      end else begin
         in_service_ff <= (nxt_state == ST_SERVE);
      end
   end

   // ----------------------------------------------------------------
   // Wakeup from Idle and Power Down
   // ----------------------------------------------------------------
   wire [SRC_COUNT-1:0] wake_src = pend & WAKE_MASK;
   wire ext_wake = pend[SRC_EXT0] | pend[SRC_EXT1];
   wire nxt_wake = (cpu_power_down && (|wake_src)) || (cpu_idle && (ext_wake || win_valid));

   // Wake request level
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wakeup_ff <= 1'b0;
      end else begin
         wakeup_ff <= nxt_wake;
      end
   end

   // ----------------------------------------------------------------
   // External flag copies
   // ----------------------------------------------------------------
   // Registered copies of the pin flags
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ext0_req_flag <= 1'b0;
         ext1_req_flag <= 1'b0;
      end else begin
         ext0_req_flag <= ext0_flag;
         ext1_req_flag <= ext1_flag;
      end
   end
endmodule

// *** pkg/pic_pkg.sv ***
/*
 Package for the four-level prioritized interrupt controller: source indices,
 register bit positions, vectors, arbitration ranks and timing counts.
 Assumes a single 20 MHz CPU clock; a machine cycle is six CPU clocks.
*/
package pic_pkg;
   // ----------------------------------------------------------------
   // Sources and sizes
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 12;
   localparam int NUM_LVL = 4;
   typedef enum logic [3:0] {
      SRC_EXT0, SRC_TMR0, SRC_EXT1, SRC_TMR1, SRC_SER, SRC_BOD,
      SRC_TWI, SRC_KEY, SRC_CMP2, SRC_WDT, SRC_CONV, SRC_CMP1
   } pic_src_t;
   typedef enum logic [1:0] {ST_IDLE, ST_SERVE} pic_state_t;

   // ----------------------------------------------------------------
   // Register bit positions (enable and priority share them)
   // ----------------------------------------------------------------
   localparam int A_EXT0 = 0;
   localparam int A_TMR0 = 1;
   localparam int A_EXT1 = 2;
   localparam int A_TMR1 = 3;
   localparam int A_SER = 4;
   localparam int A_BOD = 5;
   localparam int A_WDT = 6;
   localparam int A_GLOBAL = 7;
   localparam int B_TWI = 0;
   localparam int B_KEY = 1;
   localparam int B_CMP2 = 2;
   localparam int B_CONV = 4;
   localparam int B_CMP1 = 5;

   // ----------------------------------------------------------------
   // Vectors, ranks and wakeup capability, indexed by source
   // ----------------------------------------------------------------
   localparam logic [7:0] VEC_TAB [NUM_SRC] = '{
      8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
      8'h33, 8'h3b, 8'h43, 8'h53, 8'h5b, 8'h63};
   localparam logic [3:0] RANK_TAB [NUM_SRC] = '{
      4'h1, 4'h4, 4'h7, 4'ha, 4'hc, 4'h2,
      4'h5, 4'h8, 4'hb, 4'h3, 4'h6, 4'h9};
   localparam logic [11:0] WAKE_MASK = 12'hfa5;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int CLKS_PER_MCYC = 6;
   localparam logic [2:0] MCYC_LAST = 3'(CLKS_PER_MCYC - 1);
endpackage

// *** hw/pic_ext_sampler.sv ***
/*
 External request sampler: one pin, sampled once per machine cycle,
 level or falling-edge sensitive. Assumes pin is synchronous to clk_sys.
*/
`timescale 1ns/100ps
module pic_ext_sampler import pic_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Pin and control
   input wire logic ext_req_pin_n,
   input wire logic sample_tick,
   input wire logic trigger_type,
   input wire logic vector_ack,
   // Flag
   output logic req_flag
);
   logic prev_ff;
   logic cur_ff;
   logic edge_ff;
   logic nxt_edge;
   wire fall_seen = sample_tick & prev_ff & ~ext_req_pin_n;

   // Edge flag: set wins over the vector-time clear
   assign nxt_edge = fall_seen ? 1'b1 : (vector_ack ? 1'b0 : edge_ff);
   assign req_flag = trigger_type ? edge_ff : ~cur_ff;

   // Machine-cycle samples
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prev_ff <= 1'b1;
         cur_ff <= 1'b1;
         edge_ff <= 1'b0;
      end else begin
         if (sample_tick) begin
            prev_ff <= ext_req_pin_n;
            cur_ff <= ext_req_pin_n;
         end
         edge_ff <= trigger_type ? nxt_edge : 1'b0;
      end
   end
endmodule

// *** bench/pic_core_model.sv ***
/*
 Processor core model: takes presented vectors and returns from routines.
 Assumes lat 4'hf means a sleeping core that never takes a vector.
*/
`timescale 1ns/100ps
module pic_core_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Bench controls
   input wire logic [3:0] lat,
   input wire logic ret_go,
   // Controller side
   input wire logic irq_req_ff,
   input wire logic [7:0] irq_vector_ff,
   output logic vector_taken,
   output logic reti_done,
   output logic [7:0] taken_vec
);
   logic [3:0] wait_ff;

   // Take after lat cycles, one pulse per request, only while it stands
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wait_ff <= 4'h0;
         vector_taken <= 1'b0;
         reti_done <= 1'b0;
         taken_vec <= 8'h00;
      end else begin
         vector_taken <= 1'b0;
         reti_done <= ret_go;
         wait_ff <= 4'h0;
         if (irq_req_ff && !vector_taken && lat != 4'hf) begin
            wait_ff <= wait_ff + 4'h1;
            if (wait_ff >= lat) begin
               vector_taken <= 1'b1;
               taken_vec <= irq_vector_ff;
               wait_ff <= 4'h0;
            end
         end
      end
   end
endmodule

// *** bench/pic_top_checker.sv ***
/*
 Assertions on the controller top ports.
 Assumes it is bound into pic_top and sees only its ports.
*/
`timescale 1ns/100ps
module pic_top_checker import pic_pkg::*; (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Controls
   input wire logic [7:0] enable_reg_a,
   input wire logic [7:0] prio_low_reg_a,
   input wire logic [7:0] prio_high_reg_a,
   input wire logic [7:0] prio_low_reg_b,
   input wire logic [7:0] prio_high_reg_b,
   input wire logic ext0_req_pin_n,
   input wire logic ext0_trigger_type,
   input wire logic vector_taken,
   input wire logic cpu_idle,
   // Outputs
   input wire logic irq_req_ff,
   input wire logic [7:0] irq_vector_ff,
   input wire logic [3:0] irq_source_ff,
   input wire logic [1:0] active_level_ff,
   input wire logic in_service_ff,
   input wire logic wakeup_ff,
   input wire logic ext0_req_flag
);
   // --------
   // Level of the presented source
   // --------
   wire [11:0] hi = {prio_high_reg_b[5:4], prio_high_reg_a[6], prio_high_reg_b[2:0], prio_high_reg_a[5:0]};
   wire [11:0] lo = {prio_low_reg_b[5:4], prio_low_reg_a[6], prio_low_reg_b[2:0], prio_low_reg_a[5:0]};
   wire [1:0] src_lvl = {hi[irq_source_ff], lo[irq_source_ff]};

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_take;
      vector_taken && irq_req_ff;
   endsequence
   sequence s_take_ext0_edge;
      s_take ##0 (irq_source_ff == SRC_EXT0 && ext0_trigger_type);
   endsequence
   sequence s_low_held;
      (!ext0_trigger_type && $stable(ext0_req_pin_n)) [*8];
   endsequence

   // --------
   // Properties
   // --------
   a_vec_source: assert property (irq_req_ff |-> irq_vector_ff == VEC_TAB[irq_source_ff])
      else $error("vector does not match source");
   a_global_block: assert property (!enable_reg_a[A_GLOBAL] [*2] |-> !irq_req_ff)
      else $error("request while globally disabled");
   a_taken_drop: assert property (s_take |=> !irq_req_ff && in_service_ff)
      else $error("request stands after take");
   a_no_preempt: assert property (in_service_ff && irq_req_ff |-> src_lvl > active_level_ff)
      else $error("preempt by equal or lower level");
   a_level_follow: assert property (s_low_held |-> ext0_req_flag == !ext0_req_pin_n)
      else $error("level flag does not follow pin");
   a_edge_clear: assert property (s_take_ext0_edge |-> ##[1:2] !ext0_req_flag)
      else $error("edge flag not cleared on take");
   a_serve_level: assert property (s_take |=> active_level_ff == $past(src_lvl))
      else $error("active level not the served level");
   a_idle_wake: assert property (cpu_idle && irq_req_ff |-> ##[0:2] wakeup_ff)
      else $error("no wake from idle");
endmodule

bind pic_top pic_top_checker pic_top_checker_inst (.clk_sys, .rstn, .enable_reg_a, .prio_low_reg_a,
   .prio_high_reg_a, .prio_low_reg_b, .prio_high_reg_b, .ext0_req_pin_n, .ext0_trigger_type, .vector_taken,
   .cpu_idle, .irq_req_ff, .irq_vector_ff, .irq_source_ff, .active_level_ff, .in_service_ff, .wakeup_ff,
   .ext0_req_flag);

// *** bench/test_pic_top.sv ***
/*
 Self-checking bench for the interrupt controller with a core model.
 Assumes a 50 ns clock; per-source vectors are indexed like the flags.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module test_pic_top;
   logic clk_sys, rstn, ga, pd, idl, rs, ret_go, f0, vector_taken, reti_done, irq_req_ff, in_service_ff, wakeup_ff;
   logic [1:0] tt, active_level_ff;
   logic f1;
   logic [3:0] lat, src;
   logic [7:0] tv, irq_vector_ff;
   logic [11:0] fl, en, pl, ph;
   int fail_count, n_tests;
   logic [7:0] vt [12] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33, 8'h3b, 8'h43, 8'h53, 8'h5b, 8'h63};
   int rk [11] = '{0, 5, 9, 1, 6, 10, 2, 7, 11, 3, 8};

   // --------
   // Design and core model
   // --------
   pic_top pic_top_inst (.clk_sys, .rstn, .enable_reg_a({ga, en[9], en[5:0]}),
      .enable_reg_b({2'h0, en[11:10], 1'b0, en[8:6]}), .prio_low_reg_a({1'b0, pl[9], pl[5:0]}),
      .prio_high_reg_a({1'b0, ph[9], ph[5:0]}), .prio_low_reg_b({2'h0, pl[11:10], 1'b0, pl[8:6]}),
      .prio_high_reg_b({2'h0, ph[11:10], 1'b0, ph[8:6]}), .ext0_req_pin_n(~fl[0]), .ext1_req_pin_n(~fl[2]),
      .ext0_trigger_type(tt[0]), .ext1_trigger_type(tt[1]), .timer0_ovf_flag(fl[1]), .timer1_ovf_flag(fl[3]),
      .serial_tx_flag(fl[4] & ~rs), .serial_rx_flag(fl[4] & rs), .brownout_flag(fl[5]),
      .twowire_attention_flag(fl[6]), .keypad_flag(fl[7]), .cmp1_flag(fl[11]), .cmp2_flag(fl[8]),
      .watchdog_ovf_flag(fl[9]), .conv_done_flag(fl[10]), .vector_taken, .reti_done, .cpu_power_down(pd),
      .cpu_idle(idl), .irq_req_ff, .irq_vector_ff, .irq_source_ff(src), .active_level_ff, .in_service_ff,
      .wakeup_ff, .ext0_req_flag(f0), .ext1_req_flag(f1));
   pic_core_model pic_core_model_inst (.clk_sys, .rstn, .lat, .ret_go, .irq_req_ff, .irq_vector_ff,
      .vector_taken, .reti_done, .taken_vec(tv));

   // --------
   // Helpers
   // --------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Bounded wait for the core to take a vector
   task automatic take(input logic [7:0] v);
      int i;
      for (i = 0; i < 40 && vector_taken !== 1'b1; i++) cyc(1);
      if (i == 40) begin
         fail_count++;
         close_out();
      end
      `CHK(tv, v)
   endtask
   // Pins settle a full sample period before the return
   task automatic ret();
      cyc(8);
      ret_go = 1'b1;
      cyc(1);
      ret_go = 1'b0;
      cyc(1);
   endtask

   // --------
   // Scenarios
   // --------
   task automatic t_enable();
      for (int k = 0; k < 12; k++) begin
         en = 12'h001 << k;
         fl = 12'hfff;
         take(vt[k]);
         `CHK(src, 4'(k))
         fl = 12'h000;
         ret();
      end
      $display("enable test done");
   endtask
   task automatic t_rank();
      en = 12'hfff; pl = 12'h010; ph = 12'h010; rs = 1'b1; ga = 1'b0; fl = 12'hfff;
      cyc(12);
      `CHK(irq_req_ff, 1'b0)
      ga = 1'b1;
      take(8'h23);
      fl[4] = 1'b0;
      ret();
      for (int k = 0; k < 11; k++) begin
         take(vt[rk[k]]);
         fl[rk[k]] = 1'b0;
         ret();
      end
      $display("rank test done");
   endtask
   task automatic t_nest();
      lat = 4'h3; pl = 12'h042; ph = 12'h008; fl = 12'h002;
      take(8'h0b);
      fl[6] = 1'b1;
      cyc(10);
      `CHK(irq_req_ff, 1'b0)
      fl[3] = 1'b1;
      take(8'h1b);
      fl = 12'h040;
      cyc(2);
      `CHK(active_level_ff, 2'h2)
      ret();
      `CHK(active_level_ff, 2'h1)
      ret();
      take(8'h33);
      fl = 12'h000;
      ret();
      `CHK(in_service_ff, 1'b0)
      lat = 4'h0;
      $display("nest test done");
   endtask
   task automatic t_ext();
      pl = 12'h000; ph = 12'h000; tt = 2'h1;
      cyc(10);
      fl[0] = 1'b1; // Held high through the take and the return, then low
      take(8'h03);
      cyc(3);
      `CHK(f0, 1'b0)
      ret();
      `CHK(irq_req_ff, 1'b0)
      fl[0] = 1'b0;
      cyc(8);
      tt = 2'h0;
      fl[2] = 1'b1; // Held until taken a second time
      take(8'h13);
      `CHK(f1, 1'b1)
      ret();
      take(8'h13);
      fl[2] = 1'b0;
      ret();
      $display("external test done");
   endtask
   task automatic t_wake();
      lat = 4'hf; pd = 1'b1; fl = 12'h052;
      cyc(10);
      `CHK(wakeup_ff, 1'b0)
      fl = 12'h800;
      cyc(4);
      `CHK(wakeup_ff, 1'b1)
      fl = 12'h000; pd = 1'b0; idl = 1'b1; fl[2] = 1'b1;
      cyc(12);
      `CHK(wakeup_ff, 1'b1)
      fl = 12'h000; idl = 1'b0; lat = 4'h0;
      cyc(10);
      $display("wake test done");
   endtask

   // --------
   // Clock and main sequence
   // --------
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      rstn = 1'b0; fl = 12'h000; en = 12'h000; pl = 12'h000; ph = 12'h000; ga = 1'b1; tt = 2'h0;
      rs = 1'b0; pd = 1'b0; idl = 1'b0; ret_go = 1'b0; lat = 4'h0; fail_count = 0; n_tests = 0;
      repeat (10) @(posedge clk_sys);
      #1 rstn = 1'b1;
      cyc(2);
      t_enable();
      t_rank();
      t_nest();
      t_ext();
      t_wake();
      close_out();
   end
endmodule
